// ### rtl/uie_map.svh
// Register offsets, field positions, reset values and timing counts
`ifndef UIE_MAP_SVH
`define UIE_MAP_SVH
// ---------------------------------------------------------------
// Register offsets (byte addresses on the plain port)
// ---------------------------------------------------------------
`define UIE_IN_FLAGS_OFS      8'h02
`define UIE_OUT_FLAGS_OFS     8'h04
`define UIE_BUS_FLAGS_OFS     8'h06
`define UIE_IN_ENABLE_OFS     8'h07
`define UIE_OUT_ENABLE_OFS    8'h09
`define UIE_BUS_ENABLE_OFS    8'h0b
`define UIE_STATUS_OFS        8'h0c
`define UIE_STATUS_CLR_OFS    8'h0d
`define UIE_STATUS_EN_OFS     8'h0e
`define UIE_STATE_OFS         8'h0f
// ---------------------------------------------------------------
// Reset values and field layout
// ---------------------------------------------------------------
`define UIE_IN_ENABLE_RST     4'hf
`define UIE_OUT_ENABLE_RST    4'he
`define UIE_BUS_ENABLE_RST    4'h6
`define UIE_OUT_VALID_MASK    4'he
`define UIE_BIT_SOF           2'd3
`define UIE_BIT_RESET         2'd2
`define UIE_BIT_RESUME        2'd1
`define UIE_BIT_SUSPEND       2'd0
// ---------------------------------------------------------------
// Frame timing: one frame per millisecond
// ---------------------------------------------------------------
`define UIE_FRAME_NS          1000000
`define UIE_CLK_NS            4
`define UIE_FRAME_CYCLES      (`UIE_FRAME_NS / `UIE_CLK_NS)
`endif

// ### rtl/uie_pkg.sv
// Types shared by the interrupt enable block
package uie_pkg;
    typedef enum logic [1:0] {
        UIE_ACTIVE  = 2'b01,
        UIE_SLEEP   = 2'b10
    } uie_power_t;
endpackage : uie_pkg

// ### rtl/uie_frame_timer.sv
// Frame timer that synthesizes the frame-start event
`timescale 1ns/1ns
`include "uie_map.svh"
module uie_frame_timer import uie_pkg::*; #(
    parameter int FRAME_CYCLES = `UIE_FRAME_CYCLES
) (
    // Clock and reset
    input  wire logic mclk,
    input  wire logic reset_n,
    // Frame marks
    input  wire logic sof_seen,
    input  wire logic running,
    output logic      frame_due
);
    logic [31:0] count;

    // Restart on a real token; fire on our own when the token is late
    always_ff @(posedge mclk) begin
        if (!reset_n || !running) begin
            count     <= 32'h0;
            frame_due <= 1'b0;
        end else if (sof_seen || count == 32'(FRAME_CYCLES - 1)) begin
            count     <= 32'h0;
            frame_due <= 1'b1;
        end else begin
            count     <= count + 32'h1;
            frame_due <= 1'b0;
        end
    end
endmodule : uie_frame_timer

// ### rtl/uie_irq_enable.sv
// Interrupt flags, enables and request for the USB function controller
//
// The strobed register port was left to the implementer.
`timescale 1ns/1ns
`include "uie_map.svh"
// Behaviour
// - IN enable bits 0,1 gate endpoint 0, IN1
// - IN enable bits 2,3 gate IN2, IN3
// - OUT enable bits 1-3 gate OUT1-3; bit0 none
// - Bus enable: SOF, reset, resume, suspend gating
// - Reading a flag register clears its flags
// - Frame start raised from own frame timing
// - Resume only when suspended; reset always
module uie_irq_enable import uie_pkg::*; #(
    parameter int FRAME_CYCLES = `UIE_FRAME_CYCLES
) (
    // Clock and reset
    input  wire logic       mclk,
    input  wire logic       reset_n,
    // Register port
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_write,
    input  wire logic       reg_read,
    output logic      [7:0] reg_rdata,
    // Events from the serial engine and endpoints
    input  wire logic [3:0] in_event,
    input  wire logic [3:0] out_event,
    input  wire logic       sof_token,
    input  wire logic       bus_reset_seen,
    input  wire logic       resume_seen,
    input  wire logic       suspend_seen,
    // Interrupt outputs
    output logic            usb_irq,
    output logic            irq
);
    logic [3:0] in_flags, out_flags, bus_flags;
    logic [3:0] in_en, out_en, bus_en;
    logic [3:0] next_bus_set;
    logic [2:0] st_flags, st_en;
    uie_power_t power;
    logic       frame_due;
    logic       rd_in, rd_out, rd_bus;

    // ---------------------------------------------------------------
    // Frame timer
    // ---------------------------------------------------------------
    uie_frame_timer #(.FRAME_CYCLES(FRAME_CYCLES)) u_frame (
        .mclk      (mclk),
        .reset_n   (reset_n),
        .sof_seen  (sof_token),
        .running   (power == UIE_ACTIVE),
        .frame_due (frame_due)
    );

    // ---------------------------------------------------------------
    // Pending flags
    // ---------------------------------------------------------------
    assign rd_in  = reg_read && reg_addr == `UIE_IN_FLAGS_OFS;
    assign rd_out = reg_read && reg_addr == `UIE_OUT_FLAGS_OFS;
    assign rd_bus = reg_read && reg_addr == `UIE_BUS_FLAGS_OFS;

    // Bus events in field order
    always_comb begin
        next_bus_set = 4'h0;
        next_bus_set[`UIE_BIT_SOF]     = frame_due;
        next_bus_set[`UIE_BIT_RESET]   = bus_reset_seen;
        next_bus_set[`UIE_BIT_RESUME]  = resume_seen && power == UIE_SLEEP;
        next_bus_set[`UIE_BIT_SUSPEND] = suspend_seen;
    end

    // Read clears, but an event in the same cycle survives the read
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            in_flags  <= 4'h0;
            out_flags <= 4'h0;
            bus_flags <= 4'h0;
        end else begin
            in_flags  <= (rd_in ? 4'h0 : in_flags) | in_event;
            out_flags <= ((rd_out ? 4'h0 : out_flags) | out_event)
                         & `UIE_OUT_VALID_MASK;
            bus_flags <= (rd_bus ? 4'h0 : bus_flags) | next_bus_set;
        end
    end

    // Suspend state follows bus signalling
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            power <= UIE_ACTIVE;
        end else begin
            case (power)
                UIE_ACTIVE: if (suspend_seen) power <= UIE_SLEEP;
                UIE_SLEEP:  if (resume_seen || bus_reset_seen) power <= UIE_ACTIVE;
                default:    power <= UIE_ACTIVE;
            endcase
        end
    end

    // ---------------------------------------------------------------
    // Enable registers
    // ---------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            in_en  <= `UIE_IN_ENABLE_RST;
            out_en <= `UIE_OUT_ENABLE_RST;
            bus_en <= `UIE_BUS_ENABLE_RST;
        end else if (reg_write) begin
            if (reg_addr == `UIE_IN_ENABLE_OFS)  in_en  <= reg_wdata[3:0];
            if (reg_addr == `UIE_OUT_ENABLE_OFS) out_en <= reg_wdata[3:0] & `UIE_OUT_VALID_MASK;
            if (reg_addr == `UIE_BUS_ENABLE_OFS) bus_en <= reg_wdata[3:0];
        end
    end

    // Gated request to the core
    assign usb_irq = |(in_flags & in_en)
                   | |(out_flags & out_en)
                   | |(bus_flags & bus_en);

    // ---------------------------------------------------------------
    // Sticky status: 0 endpoint group, 1 bus group, 2 frame timer
    // ---------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            st_flags <= 3'h0;
            st_en    <= 3'h0;
        end else begin
            st_flags <= (reg_write && reg_addr == `UIE_STATUS_CLR_OFS
                         ? st_flags & ~reg_wdata[2:0] : st_flags)
                      | {frame_due, |next_bus_set,
                         |in_event | |(out_event & `UIE_OUT_VALID_MASK)};
            if (reg_write && reg_addr == `UIE_STATUS_EN_OFS) st_en <= reg_wdata[2:0];
        end
    end
    assign irq = |(st_flags & st_en);

    // Read data one cycle after the strobe
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            reg_rdata <= 8'h0;
        end else if (reg_read) begin
            case (reg_addr)
                `UIE_IN_FLAGS_OFS:   reg_rdata <= {4'h0, in_flags};
                `UIE_OUT_FLAGS_OFS:  reg_rdata <= {4'h0, out_flags};
                `UIE_BUS_FLAGS_OFS:  reg_rdata <= {4'h0, bus_flags};
                `UIE_IN_ENABLE_OFS:  reg_rdata <= {4'h0, in_en};
                `UIE_OUT_ENABLE_OFS: reg_rdata <= {4'h0, out_en};
                `UIE_BUS_ENABLE_OFS: reg_rdata <= {4'h0, bus_en};
                `UIE_STATUS_OFS:     reg_rdata <= {5'h0, st_flags};
                `UIE_STATUS_EN_OFS:  reg_rdata <= {5'h0, st_en};
                `UIE_STATE_OFS:      reg_rdata <= {6'h0, power};
                default:             reg_rdata <= 8'h0;
            endcase
        end else begin
            reg_rdata <= 8'h0;
        end
    end

    // ---------------------------------------------------------------
    // Checks
    // ---------------------------------------------------------------
    a_in_gate: assert property (@(posedge mclk) disable iff (!reset_n)
        (in_flags[1:0] & in_en[1:0]) != 2'h0 |-> usb_irq) else $error("IN gate");
    a_in_hi_gate: assert property (@(posedge mclk) disable iff (!reset_n)
        (in_flags[3:2] & in_en[3:2]) != 2'h0 |-> usb_irq) else $error("IN hi");
    a_out_bit0: assert property (@(posedge mclk) disable iff (!reset_n)
        !out_flags[0] && !out_en[0]) else $error("OUT bit0 set");
    a_bus_gate: assert property (@(posedge mclk) disable iff (!reset_n)
        (bus_flags & bus_en) != 4'h0 |-> usb_irq) else $error("bus gate");
    a_read_clear: assert property (@(posedge mclk) disable iff (!reset_n)
        rd_bus && next_bus_set == 4'h0 |=> bus_flags == 4'h0) else $error("no clear");
    a_frame_synth: assert property (@(posedge mclk) disable iff (!reset_n)
        frame_due |=> bus_flags[`UIE_BIT_SOF]) else $error("frame lost");
    a_resume_sleep: assert property (@(posedge mclk) disable iff (!reset_n)
        $rose(bus_flags[`UIE_BIT_RESUME]) |-> $past(power) == UIE_SLEEP)
        else $error("resume awake");
    a_irq_low: assert property (@(posedge mclk) disable iff (!reset_n)
        usb_irq |-> ((in_flags & in_en) | (out_flags & out_en) | (bus_flags & bus_en)) != 4'h0)
        else $error("spurious irq");
    c_irq: cover property (@(posedge mclk) disable iff (!reset_n) $rose(usb_irq));
    c_sleep: cover property (@(posedge mclk) disable iff (!reset_n) power == UIE_SLEEP);
    c_rdclr: cover property (@(posedge mclk) disable iff (!reset_n) rd_bus && bus_flags != 4'h0);
endmodule : uie_irq_enable

// ### verif/uie_core_model.sv
// Processor core side: takes the level request and counts its rising edges
`timescale 1ns/1ns
module uie_core_model (
    // Clock and reset
    input  wire logic        mclk,
    input  wire logic        reset_n,
    // Request from the block
    input  wire logic        usb_irq,
    // Count of request rising edges
    output logic      [7:0]  req_count
);
    logic req_d;
    // Level request: a new request is a low-to-high step, not a held level
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            req_d     <= 1'b0;
            req_count <= 8'h00;
        end else begin
            req_d <= usb_irq;
            if (usb_irq && !req_d) req_count <= req_count + 8'h01;
        end
    end
endmodule : uie_core_model

// ### verif/usb_irq_enable_mask_tb.sv
// Self-checking bench for the interrupt enable block
`timescale 1ns/1ns
`include "uie_map.svh"
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin \
    $display("[FAIL] %s exp %h got %h", n, e, g); err_count++; end end
module usb_irq_enable_mask_tb;
    localparam int FRAME = 1000;
    typedef struct { logic [3:0] iv, ov, bv, bx, ie, oe, be; } uie_row_t;
    logic       mclk, reset_n, reg_write, reg_read, sof_token, bus_reset_seen;
    logic       resume_seen, suspend_seen, usb_irq, irq;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, rd, req_count;
    logic [3:0] in_event, out_event;
    int         err_count, tests_run;
    // Rows: events, expected bus flags, then the three enables
    uie_row_t rows [11] = '{
        '{4'h1,4'h0,4'h0,4'h0,4'hf,4'he,4'h6}, '{4'h1,4'h0,4'h0,4'h0,4'he,4'he,4'h6},
        '{4'h2,4'h0,4'h0,4'h0,4'h2,4'h0,4'h0}, '{4'h4,4'h0,4'h0,4'h0,4'hb,4'h0,4'h0},
        '{4'h8,4'h0,4'h0,4'h0,4'h8,4'h0,4'h0}, '{4'h0,4'h1,4'h0,4'h0,4'h0,4'hf,4'h0},
        '{4'h0,4'h2,4'h0,4'h0,4'h0,4'h2,4'h0}, '{4'h0,4'h8,4'h0,4'h0,4'h0,4'h7,4'h0},
        '{4'h0,4'h0,4'h4,4'h4,4'h0,4'h0,4'h4}, '{4'h0,4'h0,4'h2,4'h0,4'h0,4'h0,4'hf},
        '{4'h0,4'h0,4'h1,4'h1,4'h0,4'h0,4'h1}};
    uie_irq_enable #(.FRAME_CYCLES(FRAME)) i_dut (.mclk(mclk), .reset_n(reset_n),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
        .reg_read(reg_read), .reg_rdata(reg_rdata), .in_event(in_event),
        .out_event(out_event), .sof_token(sof_token), .bus_reset_seen(bus_reset_seen),
        .resume_seen(resume_seen), .suspend_seen(suspend_seen), .usb_irq(usb_irq),
        .irq(irq));
    uie_core_model i_core (.mclk(mclk), .reset_n(reset_n), .usb_irq(usb_irq),
        .req_count(req_count));
    // Clock: 4 ns period
    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk) begin reg_addr <= a; reg_wdata <= d; reg_write <= 1'b1; end
        @(posedge mclk) reg_write <= 1'b0;
        #1; // Let the write land before a caller looks at outputs
    endtask : wr
    // Read data stand only in the cycle after the strobe
    task automatic rdr(input logic [7:0] a, output logic [7:0] d);
        @(posedge mclk) begin reg_addr <= a; reg_read <= 1'b1; end
        @(posedge mclk) reg_read <= 1'b0;
        #1 d = reg_rdata;
    endtask : rdr
    task automatic ev(input logic [3:0] i, input logic [3:0] o, input logic [3:0] b);
        @(posedge mclk) begin
            in_event <= i; out_event <= o; sof_token <= b[3];
            bus_reset_seen <= b[2]; resume_seen <= b[1]; suspend_seen <= b[0];
        end
        @(posedge mclk) begin
            in_event <= 4'h0; out_event <= 4'h0; sof_token <= 1'b0;
            bus_reset_seen <= 1'b0; resume_seen <= 1'b0; suspend_seen <= 1'b0;
        end
        repeat (3) @(posedge mclk);
    endtask : ev
    task automatic close_out();
        $display("checks %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : close_out
    // Watchdog: the whole run needs about 1300 cycles
    initial begin
        repeat (20000) @(posedge mclk);
        err_count++;
        close_out();
    end
    initial begin
        {reset_n, reg_write, reg_read, sof_token, bus_reset_seen} = '0;
        {resume_seen, suspend_seen, in_event, out_event, reg_addr, reg_wdata} = '0;
        repeat (10) @(posedge mclk);
        reset_n <= 1'b1;
        rdr(8'h07, rd); `CHK("in_en rst", 8'h0f, rd)
        rdr(8'h0b, rd); `CHK("bus_en rst", 8'h06, rd)
        rdr(8'h09, rd); `CHK("out_en rst", 8'h0e, rd)
        // The resume row would raise a wakeup flag if the suspend row came first
        rows[10].bv = 4'h1;
        foreach (rows[k]) begin
            wr(8'h07, {4'h0, rows[k].ie});
            wr(8'h09, {4'h0, rows[k].oe});
            wr(8'h0b, {4'h0, rows[k].be});
            ev(rows[k].iv, rows[k].ov, rows[k].bv);
            `CHK("usb_irq", |{rows[k].iv & rows[k].ie, rows[k].ov & rows[k].oe & 4'he,
                rows[k].bx & rows[k].be}, usb_irq)
            rdr(8'h02, rd); `CHK("in flags", {4'h0, rows[k].iv}, rd)
            rdr(8'h04, rd); `CHK("out flags", {4'h0, rows[k].ov & 4'he}, rd)
            rdr(8'h06, rd); `CHK("bus flags", {4'h0, rows[k].bx}, rd)
            `CHK("irq cleared", 1'b0, usb_irq)
        end
        // While suspended a wakeup is flagged
        rdr(8'h0f, rd); `CHK("asleep", 8'h02, rd)
        wr(8'h0b, 8'h02);
        ev(4'h0, 4'h0, 4'h2);
        `CHK("wakeup irq", 1'b1, usb_irq)
        rdr(8'h06, rd); `CHK("wakeup flag", 8'h02, rd)
        // Frame start token, then unmasking a pending flag
        wr(8'h0b, 8'h08);
        ev(4'h0, 4'h0, 4'h8);
        `CHK("sof irq", 1'b1, usb_irq)
        rdr(8'h06, rd); `CHK("sof flag", 8'h08, rd)
        wr(8'h07, 8'h00);
        ev(4'h4, 4'h0, 4'h0);
        `CHK("masked", 1'b0, usb_irq)
        wr(8'h07, 8'hff);
        `CHK("unmasked", 1'b1, usb_irq)
        rdr(8'h07, rd); `CHK("in_en upper", 8'h0f, rd)
        rdr(8'h02, rd);
        rdr(8'h30, rd); `CHK("unmapped", 8'h00, rd)
        // Status register, its enable and its write-one clear
        wr(8'h0e, 8'h01);
        ev(4'h1, 4'h0, 4'h0);
        `CHK("irq", 1'b1, irq)
        rdr(8'h0c, rd); `CHK("status", 1'b1, rd[0])
        wr(8'h0d, 8'h07);
        @(posedge mclk);
        `CHK("irq clr", 1'b0, irq)
        rdr(8'h02, rd);
        // No token: the frame flag still comes from the own timer
        rdr(8'h06, rd);
        repeat (FRAME + 10) @(posedge mclk);
        rdr(8'h06, rd); `CHK("frame tick", 1'b1, rd[3])
        `CHK("core saw", 1'b1, req_count > 8'h05)
        // Mid-run reset brings back the enable defaults and the awake state
        wr(8'h0b, 8'h0f);
        @(posedge mclk) reset_n <= 1'b0;
        repeat (3) @(posedge mclk);
        reset_n <= 1'b1;
        rdr(8'h0b, rd); `CHK("bus_en rst2", 8'h06, rd)
        rdr(8'h0f, rd); `CHK("awake rst2", 8'h01, rd)
        rdr(8'h0e, rd); `CHK("st_en rst2", 8'h00, rd)
        `CHK("irq rst2", 1'b0, usb_irq)
        close_out();
    end
endmodule : usb_irq_enable_mask_tb
